// ---- src/flash_pkg.sv ----
package flash_pkg;

   // opcodes
   localparam logic [7:0] OP_WRITE_UNLOCK      = 8'h06;
   localparam logic [7:0] OP_WRITE_LOCK        = 8'h04;
   localparam logic [7:0] OP_STATUS_READ       = 8'h05;
   localparam logic [7:0] OP_SUSPEND_STATUS    = 8'h09;
   localparam logic [7:0] OP_SMALL_CLEAR       = 8'h20;
   localparam logic [7:0] OP_HALF_CLEAR        = 8'h52;
   localparam logic [7:0] OP_LARGE_CLEAR       = 8'hD8;
   localparam logic [7:0] OP_ARRAY_CLEAR_A     = 8'hC7;
   localparam logic [7:0] OP_ARRAY_CLEAR_B     = 8'h60;
   localparam logic [7:0] OP_DEEP_SLEEP        = 8'hB9;
   localparam logic [7:0] OP_WAKE_AND_ID       = 8'hAB;
   localparam logic [7:0] OP_SOFT_RESET        = 8'h99;
   localparam logic [7:0] OP_WRITE_SUSPEND     = 8'hB0;
   localparam logic [7:0] OP_WRITE_RESUME      = 8'h30;

   // frame lengths in bits
   localparam logic [5:0] OPCODE_BITS          = 6'h08;
   localparam logic [5:0] ADDR_FRAME_BITS      = 6'h20;
   localparam logic [5:0] BIT_COUNT_CAP        = 6'h21;

   // array geometry
   localparam int         SMALL_REGION_LSB     = 12;
   localparam int         HALF_REGION_LSB      = 15;
   localparam int         LARGE_REGION_LSB     = 16;
   localparam int         BLOCK_IDX_W          = 7;
   localparam logic [7:0] BLOCK_COUNT          = 8'h80;

   // status byte layout
   localparam int         ST_CYCLE_ACTIVE      = 0;
   localparam int         ST_UNLOCK            = 1;
   localparam int         ST_PROG_PAUSED       = 2;
   localparam int         ST_ERASE_PAUSED      = 3;
   localparam int         ST_GUARD_LSB         = 2;
   localparam int         ST_BOOT_LOCK         = 6;

   // times
   localparam int         CLK_MHZ              = 10;
   localparam int         SECTOR_CLEAR_TIME_US = 40000;
   localparam int         HALF_CLEAR_TIME_US   = 200000;
   localparam int         BLOCK_CLEAR_TIME_US  = 300000;
   localparam int         ARRAY_CLEAR_TIME_US  = 32000000;
   localparam int         SUSPEND_LATENCY_US   = 20;
   localparam int         SLEEP_ENTRY_DELAY_US = 3;
   localparam longint     SECTOR_CLEAR_CYC     = longint'(SECTOR_CLEAR_TIME_US) * CLK_MHZ;
   localparam longint     HALF_CLEAR_CYC       = longint'(HALF_CLEAR_TIME_US) * CLK_MHZ;
   localparam longint     BLOCK_CLEAR_CYC      = longint'(BLOCK_CLEAR_TIME_US) * CLK_MHZ;
   localparam longint     ARRAY_CLEAR_CYC      = longint'(ARRAY_CLEAR_TIME_US) * CLK_MHZ;
   localparam int         SUSPEND_LATENCY_CYC  = SUSPEND_LATENCY_US * CLK_MHZ;
   localparam int         SLEEP_ENTRY_CYC      = SLEEP_ENTRY_DELAY_US * CLK_MHZ;
   localparam int         TIMER_W              = 32;

   typedef enum logic [1:0] {
      CK_SMALL = 2'b00,
      CK_HALF  = 2'b01,
      CK_LARGE = 2'b10,
      CK_ARRAY = 2'b11
   } clear_kind_t;

   typedef enum logic [2:0] {
      ST_IDLE       = 3'b000,
      ST_RUN        = 3'b001,
      ST_SUSP_WAIT  = 3'b010,
      ST_PAUSED     = 3'b011,
      ST_SLEEP_WAIT = 3'b100,
      ST_SLEEP      = 3'b101
   } seq_state_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] addr;
      logic [5:0]  nbits;
   } frame_t;

   typedef struct packed {
      clear_kind_t kind;
      logic [23:0] base;
   } clear_job_t;

endpackage

// ---- src/level_sync.sv ----
`timescale 1ns/100ps
module level_sync #(
   parameter int         W        = 1,
   parameter logic [W-1:0] INIT   = '0
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;

   // two flip-flop level synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

// ---- src/cycle_timer.sv ----
`timescale 1ns/100ps
module cycle_timer #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   input  wire logic         run,
   input  wire logic         abort,
   // result
   output logic              done
);

   logic [W-1:0] cnt_r;
   logic         live_r;

   // count down while running, hold while paused
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r  <= '0;
         live_r <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (abort) begin
            live_r <= 1'b0;
         end else if (load) begin
            cnt_r  <= load_val;
            live_r <= 1'b1;
         end else if (live_r && run) begin
            if (cnt_r <= W'(1)) begin
               live_r <= 1'b0;
               done   <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end

endmodule

// ---- src/flash_clear_sequencer.sv ----
`timescale 1ns/100ps
module flash_clear_sequencer #(
   parameter int unsigned SECTOR_CYC = int'(flash_pkg::SECTOR_CLEAR_CYC),
   parameter int unsigned HALF_CYC   = int'(flash_pkg::HALF_CLEAR_CYC),
   parameter int unsigned BLOCK_CYC  = int'(flash_pkg::BLOCK_CLEAR_CYC),
   parameter int unsigned ARRAY_CYC  = int'(flash_pkg::ARRAY_CLEAR_CYC),
   parameter int unsigned SUSP_CYC   = flash_pkg::SUSPEND_LATENCY_CYC,
   parameter int unsigned SLEEP_CYC  = flash_pkg::SLEEP_ENTRY_CYC
) (
   // system clock and reset
   input  wire logic                   clk,
   input  wire logic                   resetn,
   // serial link, clocked by its own clock
   input  wire logic                   spi_clk,
   input  wire logic                   cs_n,
   input  wire logic                   mosi,
   output logic                        miso,
   output logic                        miso_oe,
   // protection configuration
   input  wire logic [3:0]             block_guard_bits,
   input  wire logic                   boot_lock_guard,
   // page program engine handshake
   input  wire logic                   program_running,
   output logic                        program_hold,
   // array clear interface
   output logic                        clear_start,
   output flash_pkg::clear_job_t       clear_job,
   output logic                        clear_running,
   // status
   output logic                        cycle_active_flag,
   output logic                        write_unlock_latch,
   output logic                        erase_paused_flag,
   output logic                        program_paused_flag,
   output logic                        deep_sleep,
   output logic                        standby
);

   localparam int TW = flash_pkg::TIMER_W;

   // link domain state
   logic                    fresh_r;
   logic [5:0]              nbits_r;
   logic [31:0]             shift_r;
   logic [7:0]              opcode_r;
   logic [9:0]              stat_link;
   logic [7:0]              miso_sh_r;
   flash_pkg::frame_t       frame_link;

   // system domain state
   logic                    cs_n_s;
   logic                    cs_n_d_r;
   logic                    cs_rise;
   flash_pkg::frame_t       fr;
   flash_pkg::seq_state_t   state_r;
   flash_pkg::seq_state_t   state_nxt;
   flash_pkg::clear_kind_t  kind_r;
   logic [9:0]              stat_byte;
   logic                    op8;
   logic                    op32;
   logic                    busy;
   logic                    region_op;
   logic                    array_op;
   flash_pkg::clear_kind_t  req_kind;
   logic                    start_ok;
   logic                    suspend_ok;
   logic                    resume_ok;
   logic                    sleep_ok;
   logic                    wake_ok;
   logic [TW-1:0]           main_len;
   logic                    main_done;
   logic                    aux_load;
   logic [TW-1:0]           aux_len;
   logic                    aux_done;

   // start of each frame marked asynchronously while deselected
   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // bit counter and shift register, held after the frame ends
   always_ff @(posedge spi_clk or negedge resetn) begin
      if (!resetn) begin
         nbits_r  <= '0;
         shift_r  <= '0;
         opcode_r <= '0;
      end else begin
         shift_r <= {shift_r[30:0], mosi};
         if (fresh_r) begin
            nbits_r <= 6'h01;
         end else if (nbits_r != flash_pkg::BIT_COUNT_CAP) begin
            nbits_r <= nbits_r + 6'h01;
         end
         if (fresh_r) begin
            opcode_r <= {7'h00, mosi};
         end else if (nbits_r < flash_pkg::OPCODE_BITS) begin
            opcode_r <= {opcode_r[6:0], mosi};
         end
      end
   end

   assign frame_link = '{opcode: opcode_r, addr: shift_r[23:0], nbits: nbits_r};

   // status byte brought into the link domain
   level_sync #(.W(10), .INIT(10'h000)) u_stat_sync (
      .clk   (spi_clk),
      .rst_n (resetn),
      .d     (stat_byte),
      .q     (stat_link)
   );

   // status byte shifted out on falling edges after a status opcode
   always_ff @(negedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         miso_oe   <= 1'b0;
         miso_sh_r <= '0;
         miso      <= 1'b0;
      end else if (nbits_r == flash_pkg::OPCODE_BITS &&
                   (opcode_r == flash_pkg::OP_STATUS_READ ||
                    opcode_r == flash_pkg::OP_SUSPEND_STATUS)) begin
         miso_oe   <= 1'b1;
         miso      <= stat_link[7];
         miso_sh_r <= (opcode_r == flash_pkg::OP_SUSPEND_STATUS) ?
                      {3'h0, stat_link[9:8], stat_link[1:0], stat_link[7]} : {stat_link[6:0], stat_link[7]};
      end else if (miso_oe) begin
         miso      <= miso_sh_r[7];
         miso_sh_r <= {miso_sh_r[6:0], miso_sh_r[7]};
      end
   end

   // chip select into the system domain
   level_sync #(.W(1), .INIT(1'b1)) u_cs_sync (
      .clk   (clk),
      .rst_n (resetn),
      .d     (cs_n),
      .q     (cs_n_s)
   );

   // rise of chip select marks the frame as complete and stable
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_n_d_r <= 1'b1;
      end else begin
         cs_n_d_r <= cs_n_s;
      end
   end

   assign cs_rise = cs_n_s & ~cs_n_d_r;
   assign fr      = frame_link;

   // status word: 05 layout low byte, paused flags above it
   always_comb begin
      stat_byte                             = '0;
      stat_byte[flash_pkg::ST_CYCLE_ACTIVE] = cycle_active_flag;
      stat_byte[flash_pkg::ST_UNLOCK]       = write_unlock_latch;
      stat_byte[flash_pkg::ST_GUARD_LSB +: 4] = block_guard_bits;
      stat_byte[flash_pkg::ST_BOOT_LOCK]    = boot_lock_guard;
      stat_byte[9:8]                        = {erase_paused_flag, program_paused_flag};
   end

   // guarded region check: top blocks by guard code, block zero by boot lock
   function automatic logic region_guarded(input logic [23:0] a, input logic [3:0] bp, input logic bl);
      logic [7:0] blk;
      logic [7:0] top;
      blk = {1'b0, a[flash_pkg::LARGE_REGION_LSB +: flash_pkg::BLOCK_IDX_W]};
      top = (bp == 4'h0) ? 8'h00 : (bp > 4'h8) ? flash_pkg::BLOCK_COUNT : 8'(8'h01 << (bp - 4'h1));
      region_guarded = (bl && blk == 8'h00) || (blk >= flash_pkg::BLOCK_COUNT - top);
   endfunction

   // frame length checks
   assign op8  = (fr.nbits == flash_pkg::OPCODE_BITS);
   assign op32 = (fr.nbits == flash_pkg::ADDR_FRAME_BITS);

   assign busy = cycle_active_flag | program_running;

   // command classification
   always_comb begin
      region_op = 1'b1;
      req_kind  = flash_pkg::CK_SMALL;
      case (fr.opcode)
         flash_pkg::OP_SMALL_CLEAR: req_kind = flash_pkg::CK_SMALL;
         flash_pkg::OP_HALF_CLEAR:  req_kind = flash_pkg::CK_HALF;
         flash_pkg::OP_LARGE_CLEAR: req_kind = flash_pkg::CK_LARGE;
         default: begin
            region_op = 1'b0;
            req_kind  = flash_pkg::CK_ARRAY;
         end
      endcase
   end

   assign array_op = (fr.opcode == flash_pkg::OP_ARRAY_CLEAR_A) ||
                     (fr.opcode == flash_pkg::OP_ARRAY_CLEAR_B);

   // acceptance of each command at the chip select rise
   always_comb begin
      start_ok   = 1'b0;
      suspend_ok = 1'b0;
      resume_ok  = 1'b0;
      sleep_ok   = 1'b0;
      wake_ok    = 1'b0;
      if (cs_rise) begin
         if (state_r == flash_pkg::ST_SLEEP || state_r == flash_pkg::ST_SLEEP_WAIT) begin
            wake_ok = op8 && (fr.opcode == flash_pkg::OP_WAKE_AND_ID ||
                              fr.opcode == flash_pkg::OP_SOFT_RESET);
         end else begin
            start_ok = write_unlock_latch && !busy && state_r == flash_pkg::ST_IDLE && !program_paused_flag &&
                       ((region_op && op32 && !region_guarded(fr.addr, block_guard_bits, boot_lock_guard)) ||
                        (array_op && op8 && block_guard_bits == 4'h0 && !boot_lock_guard));
            suspend_ok = op8 && fr.opcode == flash_pkg::OP_WRITE_SUSPEND &&
                         ((state_r == flash_pkg::ST_RUN && kind_r != flash_pkg::CK_ARRAY) ||
                          (program_running && !program_paused_flag && state_r == flash_pkg::ST_IDLE));
            resume_ok  = op8 && fr.opcode == flash_pkg::OP_WRITE_RESUME &&
                         (state_r == flash_pkg::ST_PAUSED || program_paused_flag);
            sleep_ok   = op8 && fr.opcode == flash_pkg::OP_DEEP_SLEEP && !busy &&
                         state_r == flash_pkg::ST_IDLE;
         end
      end
   end

   // sequencer next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         flash_pkg::ST_IDLE: begin
            if (start_ok) begin
               state_nxt = flash_pkg::ST_RUN;
            end else if (sleep_ok) begin
               state_nxt = flash_pkg::ST_SLEEP_WAIT;
            end
         end
         flash_pkg::ST_RUN: begin
            if (main_done) begin
               state_nxt = flash_pkg::ST_IDLE;
            end else if (suspend_ok) begin
               state_nxt = flash_pkg::ST_SUSP_WAIT;
            end
         end
         flash_pkg::ST_SUSP_WAIT: begin
            if (aux_done) begin
               state_nxt = flash_pkg::ST_PAUSED;
            end
         end
         flash_pkg::ST_PAUSED: begin
            if (resume_ok) begin
               state_nxt = flash_pkg::ST_RUN;
            end
         end
         flash_pkg::ST_SLEEP_WAIT: begin
            if (wake_ok) begin
               state_nxt = flash_pkg::ST_IDLE;
            end else if (aux_done) begin
               state_nxt = flash_pkg::ST_SLEEP;
            end
         end
         flash_pkg::ST_SLEEP: begin
            if (wake_ok) begin
               state_nxt = flash_pkg::ST_IDLE;
            end
         end
         default: state_nxt = flash_pkg::ST_IDLE;
      endcase
   end

   // state register, reset lands in standby
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= flash_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // write-unlock latch
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_unlock_latch <= 1'b0;
      end else if (start_ok || wake_ok && fr.opcode == flash_pkg::OP_SOFT_RESET) begin
         write_unlock_latch <= 1'b0;
      end else if (cs_rise && op8 && state_r != flash_pkg::ST_SLEEP && state_r != flash_pkg::ST_SLEEP_WAIT) begin
         if (fr.opcode == flash_pkg::OP_WRITE_UNLOCK) begin
            write_unlock_latch <= 1'b1;
         end else if (fr.opcode == flash_pkg::OP_WRITE_LOCK) begin
            write_unlock_latch <= 1'b0;
         end
      end
   end

   // job capture with region base rounded down
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         kind_r      <= flash_pkg::CK_SMALL;
         clear_job   <= '0;
         clear_start <= 1'b0;
      end else begin
         clear_start <= start_ok;
         if (start_ok) begin
            kind_r         <= req_kind;
            clear_job.kind <= req_kind;
            case (req_kind)
               flash_pkg::CK_SMALL: clear_job.base <= {fr.addr[23:flash_pkg::SMALL_REGION_LSB],
                                                       {flash_pkg::SMALL_REGION_LSB{1'b0}}};
               flash_pkg::CK_HALF:  clear_job.base <= {fr.addr[23:flash_pkg::HALF_REGION_LSB],
                                                       {flash_pkg::HALF_REGION_LSB{1'b0}}};
               flash_pkg::CK_LARGE: clear_job.base <= {fr.addr[23:flash_pkg::LARGE_REGION_LSB],
                                                       {flash_pkg::LARGE_REGION_LSB{1'b0}}};
               default:             clear_job.base <= '0;
            endcase
         end
      end
   end

   // erase duration for the requested kind
   always_comb begin
      case (req_kind)
         flash_pkg::CK_SMALL: main_len = TW'(SECTOR_CYC);
         flash_pkg::CK_HALF:  main_len = TW'(HALF_CYC);
         flash_pkg::CK_LARGE: main_len = TW'(BLOCK_CYC);
         default:             main_len = TW'(ARRAY_CYC);
      endcase
   end

   // erase timer pauses while suspended, so total time is preserved
   cycle_timer #(.W(TW)) u_clear_timer (
      .clk      (clk),
      .resetn   (resetn),
      .load     (start_ok),
      .load_val (main_len),
      .run      (state_r == flash_pkg::ST_RUN),
      .abort    (1'b0),
      .done     (main_done)
   );

   // short delays: suspend latency and sleep entry
   assign aux_load = suspend_ok || sleep_ok;
   assign aux_len  = suspend_ok ? TW'(SUSP_CYC) : TW'(SLEEP_CYC);

   cycle_timer #(.W(TW)) u_aux_timer (
      .clk      (clk),
      .resetn   (resetn),
      .load     (aux_load),
      .load_val (aux_len),
      .run      (1'b1),
      .abort    (wake_ok),
      .done     (aux_done)
   );

   // program suspend tracking for the external page program engine
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         program_paused_flag <= 1'b0;
      end else if (suspend_ok && state_r == flash_pkg::ST_IDLE) begin
         program_paused_flag <= 1'b1;
      end else if (resume_ok && state_r != flash_pkg::ST_PAUSED) begin
         program_paused_flag <= 1'b0;
      end
   end

   // status outputs from flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cycle_active_flag <= 1'b0;
         erase_paused_flag <= 1'b0;
         clear_running     <= 1'b0;
         deep_sleep        <= 1'b0;
         standby           <= 1'b1;
      end else begin
         cycle_active_flag <= state_nxt == flash_pkg::ST_RUN || state_nxt == flash_pkg::ST_SUSP_WAIT;
         erase_paused_flag <= state_nxt == flash_pkg::ST_SUSP_WAIT || state_nxt == flash_pkg::ST_PAUSED;
         clear_running     <= state_nxt == flash_pkg::ST_RUN;
         deep_sleep        <= state_nxt == flash_pkg::ST_SLEEP;
         standby           <= cs_n_s && state_nxt == flash_pkg::ST_IDLE && !program_running;
      end
   end

   assign program_hold = program_paused_flag;

endmodule

// ---- bench/flash_clear_props.sv ----
`timescale 1ns/100ps
module flash_clear_props #(
   parameter int unsigned SECTOR_CYC = 60,
   parameter int unsigned HALF_CYC   = 80,
   parameter int unsigned BLOCK_CYC  = 100,
   parameter int unsigned ARRAY_CYC  = 120
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  resetn,
   // protection and status
   input wire logic [3:0]            block_guard_bits,
   input wire logic                  boot_lock_guard,
   input wire logic                  clear_start,
   input wire flash_pkg::clear_job_t clear_job,
   input wire logic                  clear_running,
   input wire logic                  cycle_active_flag,
   input wire logic                  write_unlock_latch,
   input wire logic                  erase_paused_flag,
   input wire logic                  deep_sleep,
   input wire logic                  standby
);
   int unsigned run_cnt;
   int unsigned lim;
   // running cycles of the current erase, kept across a pause
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) run_cnt <= 0;
      else if (clear_start) run_cnt <= 1;
      else if (clear_running) run_cnt <= run_cnt + 1;
   end
   // expected run length per kind
   assign lim = clear_job.kind == flash_pkg::CK_SMALL ? SECTOR_CYC : clear_job.kind == flash_pkg::CK_HALF ? HALF_CYC :
                clear_job.kind == flash_pkg::CK_LARGE ? BLOCK_CYC : ARRAY_CYC;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   start_busy_a: assert property (clear_start |-> cycle_active_flag && clear_running)
      else $error("erase start without busy flags");
   unlock_need_a: assert property (clear_start |-> $past(write_unlock_latch))
      else $error("erase started while locked");
   latch_cleared_a: assert property ($fell(cycle_active_flag) && !erase_paused_flag |-> !write_unlock_latch)
      else $error("unlock latch set at erase end");
   array_guard_a: assert property (clear_start && clear_job.kind == flash_pkg::CK_ARRAY |->
      block_guard_bits == 4'h0 && !boot_lock_guard && !$past(erase_paused_flag)) else $error("array erase not allowed");
   boot_block_a: assert property (clear_start && boot_lock_guard |-> clear_job.base[23:16] != 8'h00)
      else $error("boot block erased");
   region_align_a: assert property (clear_start |-> clear_job.kind == flash_pkg::CK_ARRAY ||
      clear_job.base[11:0] == 12'h000 && (clear_job.kind == flash_pkg::CK_SMALL || clear_job.base[14:12] == 3'h0
      && (clear_job.kind == flash_pkg::CK_HALF || !clear_job.base[15]))) else $error("region base misaligned");
   run_time_a: assert property ($fell(clear_running) && !cycle_active_flag |-> run_cnt inside {[lim-1:lim+2]})
      else $error("erase length wrong");
   sleep_idle_a: assert property (deep_sleep |-> !cycle_active_flag && !standby)
      else $error("sleep while busy or standby");
   paused_stop_a: assert property (erase_paused_flag && $past(erase_paused_flag) |-> !clear_running)
      else $error("erase runs while paused");
   // main scenarios
   cover property (clear_start && clear_job.kind == flash_pkg::CK_ARRAY);
   cover property ($rose(erase_paused_flag));
   cover property ($rose(deep_sleep));
endmodule

// ---- bench/spi_host_model.sv ----
`timescale 1ns/100ps
module spi_host_model (
   // link pins
   output logic      spi_clk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   // idle: clock still, deselected
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // one frame, msb first, 48 ns link clock
   task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
      rx = 8'h00;
      #13 cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi = d[31 - (i % 32)];
         #24 spi_clk = 1'b1;
         if (i >= 8) rx = {rx[6:0], miso};
         #24 spi_clk = 1'b0;
      end
      mosi = ~mosi;
      #24 cs_n = 1'b1;
   endtask
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
   logic clk, resetn, spi_clk, cs_n, mosi, miso, boot_lock_guard, program_running, clear_start, clear_running;
   logic cycle_active_flag, write_unlock_latch, erase_paused_flag, program_paused_flag, deep_sleep, standby;
   logic [3:0]            block_guard_bits;
   logic                  program_hold;
   flash_pkg::clear_job_t clear_job;
   logic [25:0]           exp_q[$];
   logic [7:0]            rx;
   logic [7:0]            ops[5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
   int                    err_total, cmp_count, seed, a;
   flash_clear_sequencer #(.SECTOR_CYC(60), .HALF_CYC(80), .BLOCK_CYC(100), .ARRAY_CYC(120), .SUSP_CYC(20))
      u_dut (.clk(clk), .resetn(resetn), .spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
      .miso_oe(), .block_guard_bits(block_guard_bits), .boot_lock_guard(boot_lock_guard), .clear_start(clear_start),
      .program_running(program_running), .program_hold(program_hold), .clear_job(clear_job),
      .clear_running(clear_running), .cycle_active_flag(cycle_active_flag), .write_unlock_latch(write_unlock_latch),
      .erase_paused_flag(erase_paused_flag), .program_paused_flag(program_paused_flag), .deep_sleep(deep_sleep),
      .standby(standby));
   spi_host_model u_host (.spi_clk(spi_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
   // system clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // frame plus deselect gap
   task automatic cmd(input logic [31:0] d, input int n);
      u_host.xfer(d, n, rx);
      repeat (6) @(posedge clk);
   endtask
   task automatic poll(input logic [7:0] op, input int b, input logic v);
      cmd({op, 24'h0}, 16);
      for (int i = 0; i < 300 && rx[b] !== v; i++) cmd({op, 24'h0}, 16);
      check(rx[b], v);
   endtask
   // unlock, then queue the expected job and send the erase
   task automatic erase(input int k);
      a = $random(seed) & 32'h7EFFFF;
      cmd({8'h06, 24'h0}, 8);
      exp_q.push_back({k > 2 ? 2'h3 : k[1:0],
         k > 2 ? 24'h0 : a[23:0] & (k == 0 ? 24'hFFF000 : k == 1 ? 24'hFF8000 : 24'hFF0000)});
      cmd({ops[k], a[23:0]}, k > 2 ? 8 : 32);
   endtask
   // each start compared with the model queue
   always @(posedge clk) if (clear_start === 1'b1) begin
      check({clear_job.kind, clear_job.kind == flash_pkg::CK_ARRAY ? 24'h0 : clear_job.base},
         exp_q.size() > 0 ? exp_q.pop_front() : 26'h3FFFFFF);
   end
   // watchdog
   initial begin
      #3000000;
      err_total++;
      final_report;
   end
   initial begin
      seed = 32'hdae8;
      {resetn, boot_lock_guard, program_running, block_guard_bits} = '0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      check({deep_sleep, standby, cycle_active_flag, write_unlock_latch}, 4'b0100);
      for (int k = 0; k < 5; k++) begin
         erase(k);
         poll(8'h05, 0, 1'b0);
         check(write_unlock_latch, 1'b0);
      end
      $display("test erase kinds done");
      cmd({8'h06, 24'h0}, 8);
      block_guard_bits <= 4'h1;
      boot_lock_guard <= 1'b1;
      cmd({8'h20, 24'h001000}, 31);
      cmd({8'hD8, 24'h7F1234}, 32);
      cmd({8'h20, 24'h000ABC}, 32);
      cmd({8'hC7, 24'h0}, 8);
      block_guard_bits <= 4'h0;
      boot_lock_guard <= 1'b0;
      cmd({8'h60, 24'h0}, 9);
      cmd({8'h04, 24'h0}, 8);
      cmd({8'h20, 24'h001000}, 32);
      $display("test refusals done");
      erase(2);
      cmd({8'hB9, 24'h0}, 8);
      cmd({8'hB0, 24'h0}, 8);
      poll(8'h09, 0, 1'b0);
      check(rx[3], 1'b1);
      cmd({8'h06, 24'h0}, 8);
      cmd({8'hC7, 24'h0}, 8);
      cmd({8'h04, 24'h0}, 8);
      cmd({8'h30, 24'h0}, 8);
      check(erase_paused_flag, 1'b0);
      poll(8'h05, 0, 1'b0);
      check(deep_sleep, 1'b0);
      program_running <= 1'b1;
      cmd({8'hB0, 24'h0}, 8);
      poll(8'h09, 2, 1'b1);
      check(program_hold, 1'b1);
      cmd({8'h30, 24'h0}, 8);
      check(program_paused_flag, 1'b0);
      program_running <= 1'b0;
      $display("test suspend done");
      cmd({8'hB9, 24'h0}, 9);
      repeat (40) @(posedge clk);
      check(deep_sleep, 1'b0);
      for (int i = 0; i < 2; i++) begin
         cmd({8'hB9, 24'h0}, 8);
         repeat (40) @(posedge clk);
         check({deep_sleep, standby}, 2'b10);
         cmd({8'h06, 24'h0}, 8);
         check(write_unlock_latch, 1'b0);
         cmd({i ? 8'h99 : 8'hAB, 24'h0}, 8);
         check({deep_sleep, standby}, 2'b01);
      end
      $display("test sleep done");
      final_report;
   end
endmodule
bind flash_clear_sequencer flash_clear_props #(.SECTOR_CYC(SECTOR_CYC), .HALF_CYC(HALF_CYC), .BLOCK_CYC(BLOCK_CYC),
   .ARRAY_CYC(ARRAY_CYC)) u_props (.clk(clk), .resetn(resetn), .block_guard_bits(block_guard_bits),
   .boot_lock_guard(boot_lock_guard), .clear_start(clear_start), .clear_job(clear_job), .clear_running(clear_running),
   .cycle_active_flag(cycle_active_flag), .write_unlock_latch(write_unlock_latch),
   .erase_paused_flag(erase_paused_flag), .deep_sleep(deep_sleep), .standby(standby));
